//--- dal_gate.sv
// How it works
// - The boot-loader range 0x1000 to 0x17ff is fixed and every write aimed at it is refused.
// - On UART variants the boot loader talks only through the serial module tx and rx pins.
// - A disable signature at the boot-loader signature word turns the boot loader off.
// - Only the factory-chosen boot-loader interface, UART or I2C, is ever enabled.
// - The lock signature at the debug signature word blocks all JTAG access.
// - After the boot loader has checked its password the lock may be cleared, reopening JTAG.
// - The debug password is read from 0xff88 onward and is one to four 16-bit words long.
// - A wrong password leaves JTAG denied.
// - A verified password opens JTAG until the next brownout reset.
// - The calibration record area refuses every erase or write from any source.
// - The calibration record carries a per-device random seed readable like other fields.
`timescale 1ns/100ps
module dal_gate
  import dal_pkg::*;
#(
  parameter logic        BOOT_IF_UART = 1'b1,
  parameter logic [95:0] CAL_FIELDS   = 96'h0,
  parameter logic [31:0] CAL_SEED     = 32'h0
)
(
  // clock and brownout reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // nonvolatile read port
  output logic             o_nv_rd,
  output logic [15:0]      o_nv_addr,
  input  wire logic        i_nv_rvalid,
  input  wire logic [15:0] i_nv_rdata,
  input  wire logic [2:0]  i_pw_len,
  // password entry from the debug port
  input  wire logic        i_pw_valid,
  input  wire logic [15:0] i_pw_word,
  output logic             o_pw_fail,
  output logic             o_jtag_en,
  // write guard
  input  wire logic        i_wr_req,
  input  wire logic [15:0] i_wr_addr,
  output logic             o_wr_grant,
  output logic             o_wr_deny,
  // boot loader
  input  wire logic        i_boot_auth,
  input  wire logic        i_fuse_clear_req,
  output logic             o_fuse_clear,
  output logic             o_boot_uart_en,
  output logic             o_boot_i2c_en,
  input  wire logic        i_boot_tx,
  output logic             o_boot_rx,
  output logic             o_serial_tx_pin,
  input  wire logic        i_serial_rx_pin,
  // calibration record
  input  wire logic        i_cal_rd,
  input  wire logic [2:0]  i_cal_idx,
  output logic [15:0]      o_cal_data,
  output logic             o_cal_valid
);

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_reg;
  logic       rst_b;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_b = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // startup scan of signatures and password
  dal_state_t  state_reg;
  dal_state_t  state_next;
  logic        pend_reg;
  logic [2:0]  scan_idx_reg;
  logic [15:0] pw_mem_reg [DAL_PW_MAX];
  logic        fuse_lock_reg;
  logic        pw_lock_reg;
  logic        boot_off_reg;
  logic [2:0]  len_w;
  logic [15:0] scan_addr_w;
  logic        got_w;
  logic        last_scan_w;

  // out-of-range length is clamped rather than trusted
  assign len_w = (i_pw_len == 3'h0) ? 3'h1 :
                 (i_pw_len > DAL_PW_LEN_MAX) ? DAL_PW_LEN_MAX : i_pw_len;
  assign scan_addr_w = (state_reg == ST_RD_JSIG) ? DAL_JSIG_ADDR :
                       (state_reg == ST_RD_BSIG) ? DAL_BSIG_ADDR :
                       DAL_PW_BASE + {12'h000, scan_idx_reg, 1'b0};
  assign got_w       = pend_reg && i_nv_rvalid;
  assign last_scan_w = (scan_idx_reg == len_w - 3'h1);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RD_JSIG : if (got_w) state_next = ST_RD_BSIG;
      ST_RD_BSIG : if (got_w) state_next = ST_RD_PW;
      ST_RD_PW   : if (got_w && last_scan_w) state_next = ST_RUN;
      ST_RUN     : state_next = ST_RUN;
      default    : state_next = ST_RD_JSIG;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg     <= ST_RD_JSIG;
      pend_reg      <= 1'b0;
      o_nv_rd       <= 1'b0;
      o_nv_addr     <= DAL_WORD_RST;
      scan_idx_reg  <= DAL_IDX_RST;
      fuse_lock_reg <= 1'b1;
      pw_lock_reg   <= 1'b1;
      boot_off_reg  <= 1'b1;
      for (int k = 0; k < DAL_PW_MAX; k++)
        pw_mem_reg[k] <= DAL_WORD_RST;
    end
    else
    begin
      state_reg <= state_next;
      o_nv_rd   <= (state_reg != ST_RUN) && !pend_reg && !o_nv_rd;
      if ((state_reg != ST_RUN) && !pend_reg && !o_nv_rd)
        o_nv_addr <= scan_addr_w;
      if (o_nv_rd)
        pend_reg <= 1'b1;
      else if (got_w)
        pend_reg <= 1'b0;
      if (got_w && state_reg == ST_RD_JSIG)
      begin
        fuse_lock_reg <= (i_nv_rdata == DAL_SIG_FUSE);
        pw_lock_reg   <= (i_nv_rdata == DAL_SIG_PW);
      end
      if (got_w && state_reg == ST_RD_BSIG)
        boot_off_reg <= (i_nv_rdata == DAL_SIG_BOOT_OFF);
      if (got_w && state_reg == ST_RD_PW)
      begin
        pw_mem_reg[scan_idx_reg[1:0]] <= i_nv_rdata;
        scan_idx_reg <= scan_idx_reg + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // password entry and JTAG gate
  logic       unlocked_reg;
  logic       fuse_clr_reg;
  logic       auth_reg;
  logic [2:0] ent_idx_reg;
  logic       ent_bad_reg;
  logic       ent_w;
  logic       ent_last_w;
  logic       ent_match_w;
  logic       pw_ok_w;
  logic       pw_fail_w;
  logic       clear_hit_w;
  logic       boot_en_w;
  logic       jtag_w;

  assign ent_w       = (state_reg == ST_RUN) && pw_lock_reg && !unlocked_reg && i_pw_valid;
  assign ent_match_w = (i_pw_word == pw_mem_reg[ent_idx_reg[1:0]]);
  assign ent_last_w  = (ent_idx_reg == len_w - 3'h1);
  assign pw_ok_w     = ent_w && ent_last_w && !ent_bad_reg && ent_match_w;
  assign pw_fail_w   = ent_w && ent_last_w && (ent_bad_reg || !ent_match_w);
  assign boot_en_w   = (state_reg == ST_RUN) && !boot_off_reg;
  assign clear_hit_w = boot_en_w && auth_reg && i_fuse_clear_req;
  // nothing passes until the scan finishes and both locks are satisfied
  assign jtag_w      = (state_reg == ST_RUN) && !(fuse_lock_reg && !fuse_clr_reg) &&
                       (!pw_lock_reg || unlocked_reg);

  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      unlocked_reg <= 1'b0;
      fuse_clr_reg <= 1'b0;
      auth_reg     <= 1'b0;
      ent_idx_reg  <= DAL_IDX_RST;
      ent_bad_reg  <= 1'b0;
      o_pw_fail    <= 1'b0;
      o_jtag_en    <= 1'b0;
      o_fuse_clear <= 1'b0;
    end
    else
    begin
      // only brownout reset clears these
      if (pw_ok_w)
        unlocked_reg <= 1'b1;
      if (clear_hit_w)
        fuse_clr_reg <= 1'b1;
      if (i_boot_auth && boot_en_w)
        auth_reg <= 1'b1;
      if (ent_w)
      begin
        ent_idx_reg <= ent_last_w ? DAL_IDX_RST : ent_idx_reg + 3'h1;
        ent_bad_reg <= ent_last_w ? 1'b0 : (ent_bad_reg || !ent_match_w);
      end
      o_pw_fail    <= pw_fail_w;
      o_jtag_en    <= jtag_w;
      o_fuse_clear <= clear_hit_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write guard for fixed and protected regions
  logic deny_w;

  assign deny_w = in_range(i_wr_addr, DAL_BOOT_LO, DAL_BOOT_HI) ||
                  in_range(i_wr_addr, DAL_CAL_LO, DAL_CAL_HI);

  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_wr_grant <= 1'b0;
      o_wr_deny  <= 1'b0;
    end
    else
    begin
      o_wr_grant <= i_wr_req && !deny_w;
      o_wr_deny  <= i_wr_req && deny_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot-loader interface selection and serial pins
  logic [2:0] rx_sync_reg;
  logic       uart_w;

  assign uart_w = boot_en_w && BOOT_IF_UART;

  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_sync_reg     <= 3'b111;
      o_boot_rx       <= 1'b1;
      o_serial_tx_pin <= 1'b1;
      o_boot_uart_en  <= 1'b0;
      o_boot_i2c_en   <= 1'b0;
    end
    else
    begin
      rx_sync_reg     <= {rx_sync_reg[1:0], i_serial_rx_pin};
      // idle high while the boot loader is not on the pins
      o_serial_tx_pin <= uart_w ? i_boot_tx : 1'b1;
      if (!uart_w)
        o_boot_rx <= 1'b1;
      else if (rx_sync_reg[1] == rx_sync_reg[2])
        o_boot_rx <= rx_sync_reg[2];
      o_boot_uart_en  <= uart_w;
      o_boot_i2c_en   <= boot_en_w && !BOOT_IF_UART;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  dal_cal_if cal_bus ();

  assign cal_bus.rd  = i_cal_rd;
  assign cal_bus.idx = i_cal_idx;
  assign o_cal_data  = cal_bus.data;
  assign o_cal_valid = cal_bus.valid;

  dal_cal_mem #(
    .CAL_FIELDS (CAL_FIELDS),
    .CAL_SEED   (CAL_SEED)
  ) u_cal (
    .i_clk   (i_clk),
    .i_rst_b (rst_b),
    .cal     (cal_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_b);

  chk_boot_write_deny : assert property (
    i_wr_req && in_range(i_wr_addr, DAL_BOOT_LO, DAL_BOOT_HI) |=> o_wr_deny && !o_wr_grant)
    else $error("boot-loader write not refused");
  chk_tx_pin_route : assert property (
    uart_w |=> o_serial_tx_pin == $past(i_boot_tx))
    else $error("tx pin not carrying boot loader");
  chk_boot_disabled : assert property (
    boot_off_reg |=> !o_boot_uart_en && !o_boot_i2c_en)
    else $error("disabled boot loader offered");
  chk_one_iface : assert property (
    BOOT_IF_UART ? !o_boot_i2c_en : !o_boot_uart_en)
    else $error("wrong boot-loader interface");
  chk_fuse_blocks : assert property (
    fuse_lock_reg && !fuse_clr_reg |=> !o_jtag_en)
    else $error("jtag open under fuse lock");
  chk_fuse_clear : assert property (
    clear_hit_w && !pw_lock_reg |=> o_fuse_clear ##1 o_jtag_en)
    else $error("fuse clear did not reopen jtag");
  chk_pw_addr : assert property (
    o_nv_rd && state_reg == ST_RD_PW |-> o_nv_addr[15:3] == DAL_PW_BASE[15:3])
    else $error("password read outside its location");
  chk_pw_bad_denies : assert property (
    pw_fail_w |=> !unlocked_reg && o_pw_fail)
    else $error("wrong password unlocked");
  chk_unlock_holds : assert property (
    pw_ok_w |=> unlocked_reg [*8])
    else $error("unlock not held");
  chk_cal_deny : assert property (
    i_wr_req && in_range(i_wr_addr, DAL_CAL_LO, DAL_CAL_HI) |=> o_wr_deny)
    else $error("calibration write not refused");
  chk_locked_boot : assert property (
    state_reg != ST_RUN |=> !o_jtag_en)
    else $error("jtag open before scan done");

  cov_unlock    : cover property (pw_ok_w ##2 o_jtag_en);
  cov_pw_fail   : cover property (pw_fail_w);
  cov_fuse_clr  : cover property (clear_hit_w);
  cov_wr_denied : cover property (o_wr_deny);

endmodule

//--- dal_pkg.sv
package dal_pkg;

  // nonvolatile map
  localparam logic [15:0] DAL_BOOT_LO     = 16'h1000;
  localparam logic [15:0] DAL_BOOT_HI     = 16'h17ff;
  localparam logic [15:0] DAL_PW_BASE     = 16'hff88;
  localparam logic [15:0] DAL_JSIG_ADDR   = 16'hff80;
  localparam logic [15:0] DAL_BSIG_ADDR   = 16'hff84;
  localparam logic [15:0] DAL_CAL_LO      = 16'h1a00;
  localparam logic [15:0] DAL_CAL_HI      = 16'h1a0f;

  // signature values
  localparam logic [15:0] DAL_SIG_FUSE    = 16'h5555;
  localparam logic [15:0] DAL_SIG_PW      = 16'haaaa;
  localparam logic [15:0] DAL_SIG_BOOT_OFF = 16'h5555;

  // password and calibration record sizes
  localparam int          DAL_PW_MAX      = 4;
  localparam logic [2:0]  DAL_PW_LEN_MAX  = 3'h4;
  localparam int          DAL_CAL_WORDS   = 8;
  localparam logic [2:0]  DAL_CAL_SEED_LO = 3'h6;
  localparam logic [2:0]  DAL_CAL_SEED_HI = 3'h7;

  // reset values
  localparam logic [15:0] DAL_WORD_RST    = 16'h0000;
  localparam logic [2:0]  DAL_IDX_RST     = 3'h0;

  typedef enum logic [1:0]
  {
    ST_RD_JSIG = 2'b00,
    ST_RD_BSIG = 2'b01,
    ST_RD_PW   = 2'b10,
    ST_RUN     = 2'b11
  } dal_state_t;

endpackage

//--- dal_cal_if.sv
`timescale 1ns/100ps
interface dal_cal_if;
  logic        rd;
  logic [2:0]  idx;
  logic [15:0] data;
  logic        valid;

  modport mem
  (
    input  rd,
    input  idx,
    output data,
    output valid
  );

  modport user
  (
    output rd,
    output idx,
    input  data,
    input  valid
  );
endinterface

//--- dal_cal_mem.sv
`timescale 1ns/100ps
module dal_cal_mem
  import dal_pkg::*;
#(
  parameter logic [95:0] CAL_FIELDS = 96'h0,
  parameter logic [31:0] CAL_SEED   = 32'h0
)
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // read port
  dal_cal_if.mem    cal
);

  ////////////////////////////////////////////////////////////////////////////
  // no write port at all: the record cannot be altered from any source
  logic [15:0] table_w [DAL_CAL_WORDS];

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_field
      assign table_w[g] = CAL_FIELDS[16*g +: 16];
    end
  endgenerate
  assign table_w[DAL_CAL_SEED_LO] = CAL_SEED[15:0];
  assign table_w[DAL_CAL_SEED_HI] = CAL_SEED[31:16];

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] data_reg;
  logic        valid_reg;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      data_reg  <= DAL_WORD_RST;
      valid_reg <= 1'b0;
    end
    else
    begin
      valid_reg <= cal.rd;
      if (cal.rd)
        data_reg <= table_w[cal.idx];
    end
  end

  assign cal.data  = data_reg;
  assign cal.valid = valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  chk_seed_readable : assert property (@(posedge i_clk) disable iff (!i_rst_b)
    cal.rd && cal.idx == DAL_CAL_SEED_LO |=> cal.valid && cal.data == CAL_SEED[15:0])
    else $error("seed word not returned");

endmodule

//--- dal_nv_model.sv
`timescale 1ns/100ps
module dal_nv_model
  import dal_pkg::*;
(
  // clock, reset, answer speed
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_slow,
  // stored words
  input  wire logic [15:0] i_jsig,
  input  wire logic [15:0] i_bsig,
  input  wire logic [15:0] i_pw0,
  input  wire logic [15:0] i_pw1,
  // read port
  input  wire logic        i_nv_rd,
  input  wire logic [15:0] i_nv_addr,
  output logic             o_nv_rvalid,
  output logic [15:0]      o_nv_rdata,
  output logic [3:0]       o_reads
);
  logic        pend_reg;
  logic [1:0]  wait_reg;
  logic [15:0] word;
  ////////////////////////////////////////////////////////////////////////////
  assign word = (i_nv_addr == DAL_JSIG_ADDR) ? i_jsig :
                (i_nv_addr == DAL_BSIG_ADDR) ? i_bsig :
                (i_nv_addr == DAL_PW_BASE) ? i_pw0 :
                (i_nv_addr == DAL_PW_BASE + 16'h2) ? i_pw1 : 16'hffff;
  ////////////////////////////////////////////////////////////////////////////
  // data toggles when not valid so a stale sample cannot pass
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pend_reg    <= 1'b0;
      wait_reg    <= 2'h0;
      o_reads     <= 4'h0;
      o_nv_rvalid <= 1'b0;
      o_nv_rdata  <= 16'h0000;
    end
    else
    begin
      o_nv_rvalid <= 1'b0;
      o_nv_rdata  <= ~o_nv_rdata;
      if (i_nv_rd)
      begin
        pend_reg <= 1'b1;
        wait_reg <= i_slow ? 2'h3 : 2'h0;
        o_reads  <= o_reads + 4'h1;
      end
      else if (pend_reg && wait_reg != 2'h0)
        wait_reg <= wait_reg - 2'h1;
      else if (pend_reg)
      begin
        pend_reg    <= 1'b0;
        o_nv_rvalid <= 1'b1;
        o_nv_rdata  <= word;
      end
    end
  end
endmodule

//--- dal_gate_tb.sv
`timescale 1ns/100ps
module dal_gate_tb;
  import dal_pkg::*;
  localparam logic [95:0] CALF = 96'h0605_0504_0403_0302_0201_0100;
  localparam logic [31:0] SEED = 32'hc3a5_5a3c;
  logic clk, rst_b, slow, nv_rd, nv_rvalid, pw_valid, pw_fail, jtag_en;
  logic wr_req, wr_grant, wr_deny, boot_auth, fclr_req, fuse_clear, uart_en;
  logic i2c_en, boot_tx, boot_rx, tx_pin, rx_pin, cal_rd, cal_valid;
  logic uart_en2, i2c_en2, boot_rx2, tx_pin2;
  logic [15:0] nv_addr, nv_rdata, pw_word, wr_addr, cal_data, jsig, bsig;
  logic [2:0]  cal_idx, pw_len;
  logic [3:0]  reads;
  int          n_mismatch = 0;
  int          compares = 0;
  ////////////////////////////////////////////////////////////////////////////
  dal_gate #(.BOOT_IF_UART(1'b1), .CAL_FIELDS(CALF), .CAL_SEED(SEED)) dal_gate_i
  (
    .i_clk(clk), .i_rst_b(rst_b), .o_nv_rd(nv_rd), .o_nv_addr(nv_addr),
    .i_nv_rvalid(nv_rvalid), .i_nv_rdata(nv_rdata), .i_pw_len(pw_len),
    .i_pw_valid(pw_valid), .i_pw_word(pw_word), .o_pw_fail(pw_fail),
    .o_jtag_en(jtag_en), .i_wr_req(wr_req), .i_wr_addr(wr_addr),
    .o_wr_grant(wr_grant), .o_wr_deny(wr_deny), .i_boot_auth(boot_auth),
    .i_fuse_clear_req(fclr_req), .o_fuse_clear(fuse_clear),
    .o_boot_uart_en(uart_en), .o_boot_i2c_en(i2c_en), .i_boot_tx(boot_tx),
    .o_boot_rx(boot_rx), .o_serial_tx_pin(tx_pin), .i_serial_rx_pin(rx_pin),
    .i_cal_rd(cal_rd), .i_cal_idx(cal_idx), .o_cal_data(cal_data),
    .o_cal_valid(cal_valid)
  );
  // i2c variant runs in lockstep on the same answers; its own reads go unused
  dal_gate #(.BOOT_IF_UART(1'b0), .CAL_FIELDS(CALF), .CAL_SEED(SEED)) dal_gate_i2c_i
  (
    .i_clk(clk), .i_rst_b(rst_b), .o_nv_rd(), .o_nv_addr(),
    .i_nv_rvalid(nv_rvalid), .i_nv_rdata(nv_rdata), .i_pw_len(pw_len),
    .i_pw_valid(pw_valid), .i_pw_word(pw_word), .o_pw_fail(),
    .o_jtag_en(), .i_wr_req(wr_req), .i_wr_addr(wr_addr),
    .o_wr_grant(), .o_wr_deny(), .i_boot_auth(boot_auth),
    .i_fuse_clear_req(fclr_req), .o_fuse_clear(),
    .o_boot_uart_en(uart_en2), .o_boot_i2c_en(i2c_en2), .i_boot_tx(boot_tx),
    .o_boot_rx(boot_rx2), .o_serial_tx_pin(tx_pin2), .i_serial_rx_pin(rx_pin),
    .i_cal_rd(cal_rd), .i_cal_idx(cal_idx), .o_cal_data(),
    .o_cal_valid()
  );
  dal_nv_model dal_nv_model_i
  (
    .i_clk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_jsig(jsig), .i_bsig(bsig),
    .i_pw0(16'h1357), .i_pw1(16'h2468), .i_nv_rd(nv_rd), .i_nv_addr(nv_addr),
    .o_nv_rvalid(nv_rvalid), .o_nv_rdata(nv_rdata), .o_reads(reads)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (compares > 0 && n_mismatch == 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // scan reads jsig, bsig and ln password words before the port opens
  task automatic boot(input logic [15:0] js, input logic [15:0] bs, input logic sl,
                      input logic [2:0] ln);
    @(posedge clk);
    jsig   <= js;
    bsig   <= bs;
    slow   <= sl;
    pw_len <= ln;
    rst_b  <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 60 && reads < 4'h4; k++)
    begin
      @(posedge clk);
      #1 chk("jtag_scan", 16'h0, jtag_en);
    end
    repeat (8) @(posedge clk);
    // two signature words plus one read per password word
    #1 chk("nv_reads", 16'h2 + {13'h0000, ln}, {12'h000, reads});
  endtask
  task automatic wr(input logic [15:0] a, input logic deny);
    @(posedge clk);
    wr_req  <= 1'b1;
    wr_addr <= a;
    @(posedge clk);
    wr_req <= 1'b0;
    #1 chk("wr_deny", deny, wr_deny);
    chk("wr_grant", !deny, wr_grant);
  endtask
  task automatic pw(input logic [15:0] w0, input logic [15:0] w1, input logic ok);
    @(posedge clk);
    pw_valid <= 1'b1;
    pw_word  <= w0;
    @(posedge clk);
    pw_word <= w1;
    @(posedge clk);
    pw_valid <= 1'b0;
    #1 chk("pw_fail", !ok, pw_fail);
    @(posedge clk);
    #1 chk("jtag_pw", ok, jtag_en);
  endtask
  task automatic clr(input logic au, input logic ok);
    @(posedge clk);
    boot_auth <= au;
    @(posedge clk);
    boot_auth <= 1'b0;
    fclr_req  <= 1'b1;
    @(posedge clk);
    fclr_req <= 1'b0;
    #1 chk("fuse_clear", ok, fuse_clear);
    @(posedge clk);
    #1 chk("jtag_clr", ok, jtag_en);
  endtask
  task automatic cal(input logic [2:0] ix, input logic [15:0] exp);
    @(posedge clk);
    cal_rd  <= 1'b1;
    cal_idx <= ix;
    @(posedge clk);
    cal_rd <= 1'b0;
    #1 chk("cal_valid", 16'h1, cal_valid);
    chk("cal_data", exp, cal_data);
  endtask
  // rx passes a filter, so allow more than its few cycles
  task automatic ser(input logic v);
    @(posedge clk);
    boot_tx <= v;
    rx_pin  <= v;
    @(posedge clk);
    #1 chk("tx_pin", v, tx_pin);
    chk("tx_pin_i2c", 16'h1, tx_pin2);
    repeat (6) @(posedge clk);
    #1 chk("boot_rx", v, boot_rx);
    chk("boot_rx_i2c", 16'h1, boot_rx2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    {rst_b, slow, pw_valid, wr_req, boot_auth, fclr_req, cal_rd} = 7'h00;
    {boot_tx, rx_pin} = 2'b11;
    {jsig, bsig, pw_word, wr_addr} = 64'h0;
    cal_idx = 3'h0;
    pw_len  = 3'h2;
    boot(16'h1234, 16'h0000, 1'b0, 3'h2);
    chk("jtag_open", 16'h1, jtag_en);
    chk("uart_en", 16'h1, uart_en);
    chk("i2c_en", 16'h0, i2c_en);
    chk("uart_en_i2c", 16'h0, uart_en2);
    chk("i2c_en_i2c", 16'h1, i2c_en2);
    wr(16'h0fff, 1'b0);
    wr(16'h1000, 1'b1);
    wr(16'h17ff, 1'b1);
    wr(16'h1800, 1'b0);
    wr(16'h1a00, 1'b1);
    wr(16'h1a0f, 1'b1);
    wr(16'h1a10, 1'b0);
    cal(3'h6, SEED[15:0]);
    cal(3'h7, SEED[31:16]);
    cal(3'h0, CALF[15:0]);
    ser(1'b0);
    ser(1'b1);
    boot(DAL_SIG_PW, 16'h0000, 1'b1, 3'h2);
    chk("jtag_pwlock", 16'h0, jtag_en);
    pw(16'h1357, 16'h2469, 1'b0);
    pw(16'h1356, 16'h2468, 1'b0);
    pw(16'h1357, 16'h2468, 1'b1);
    boot(DAL_SIG_PW, 16'h0000, 1'b0, 3'h1);
    chk("jtag_rearm", 16'h0, jtag_en);
    pw(16'h1357, 16'h0000, 1'b1);
    boot(DAL_SIG_FUSE, 16'h0000, 1'b0, 3'h2);
    chk("jtag_fuse", 16'h0, jtag_en);
    clr(1'b0, 1'b0);
    clr(1'b1, 1'b1);
    boot(DAL_SIG_FUSE, DAL_SIG_BOOT_OFF, 1'b1, 3'h2);
    chk("uart_off", 16'h0, uart_en);
    chk("i2c_off", 16'h0, i2c_en);
    chk("i2c_off_i2c", 16'h0, i2c_en2);
    clr(1'b1, 1'b0);
    give_verdict();
  end
endmodule
